// *** hw/issue_sched_defs.svh ***
`ifndef ISSUE_SCHED_DEFS_SVH
`define ISSUE_SCHED_DEFS_SVH

// Pipeline depth in levels of the reservation FIFO
`define RSV_DEPTH 8
// Write ports of the register set
`define WR_PORTS 2
// Register number width
`define REG_W 6
// Latency field width
`define LAT_W 4
// Latency of a multiply and an addition
`define LAT_MUL 4'h6
`define LAT_ADD 4'h2
// Load that hits the buffer: buffer, shuffler, crossbar, register set
`define LAT_LOAD_HIT 4'h4
// Divider cycle counts per size code
`define DIV_CYC_B 7'h08
`define DIV_CYC_D 7'h10
`define DIV_CYC_Q 7'h20
`define DIV_CYC_O 7'h40
// Size codes
`define SZ_BYTE 2'h0
`define SZ_DBYTE 2'h1
`define SZ_QBYTE 2'h2
`define SZ_OBYTE 2'h3

`endif

// *** hw/issue_sched_pkg.sv ***
`default_nettype none
package issue_sched_pkg;
    // Kind of instruction as seen by the scheduler
    typedef enum logic [2:0] {
        K_FIXED,
        K_DIV,
        K_LOAD,
        K_GETPUT,
        K_NOP
    } ikind_t;
endpackage : issue_sched_pkg
`default_nettype wire

// *** hw/div_tracker.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "issue_sched_defs.svh"

module div_tracker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [1:0] size,
    output logic busy,
    output logic done
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    // ----------------------------------------
    // Size decode
    // ----------------------------------------
    function automatic logic [6:0] div_cycles(input logic [1:0] sz);
        case (sz)
            `SZ_BYTE: div_cycles = `DIV_CYC_B;
            `SZ_DBYTE: div_cycles = `DIV_CYC_D;
            `SZ_QBYTE: div_cycles = `DIV_CYC_Q;
            default: div_cycles = `DIV_CYC_O;
        endcase
    endfunction : div_cycles

    always_comb
    begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (start && cnt_r == 7'h00)
        begin
            cnt_nxt = div_cycles(size);
        end
        else if (cnt_r != 7'h00)
        begin
            cnt_nxt = cnt_r - 7'h01;
        end
        // Flag the result a full FIFO depth early so it can enter the empty top line
        done_nxt = (cnt_nxt == 7'(`RSV_DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= 7'h00;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = (cnt_r != 7'h00);
    assign done = done_r;

    div_len_a: assert property (@(posedge clk) disable iff (rst)
        (start && !busy && size == 2'h0) |=> (cnt_r == 7'h08) && done ##8 !busy)
        else $error("divider count wrong");
endmodule : div_tracker
`default_nettype wire

// *** hw/score_board.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "issue_sched_defs.svh"

module score_board
(
    input wire logic clk,
    input wire logic rst,
    input wire logic set_en,
    input wire logic [5:0] set_reg,
    input wire logic [1:0] clr_en,
    input wire logic [11:0] clr_reg,
    output logic [63:0] busy
);
    logic [63:0] busy_r;
    logic [63:0] busy_nxt;

    always_comb
    begin
        busy_nxt = busy_r;
        for (int p = 0; p < `WR_PORTS; p++)
        begin
            if (clr_en[p])
            begin
                busy_nxt[clr_reg[p*6 +: 6]] = 1'b0;
            end
        end
        if (set_en)
        begin
            busy_nxt[set_reg] = 1'b1;
        end
        // Register zero never holds a pending result
        busy_nxt[0] = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy_r <= 64'h0;
        end
        else
        begin
            busy_r <= busy_nxt;
        end
    end

    assign busy = busy_r;

    sb_clear_a: assert property (@(posedge clk) disable iff (rst)
        (clr_en[0] && !(set_en && set_reg == clr_reg[5:0])) |=> !busy_r[$past(clr_reg[5:0])])
        else $error("busy bit not cleared");
endmodule : score_board
`default_nettype wire

// *** hw/issue_scheduler_writeport.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "issue_sched_defs.svh"

// How it works
// - Crossbar gates of both write ports are driven every cycle.
// - Hold issue when both ports are reserved at the completion level.
// - An issuing instruction gets a write port still free at that level.
// - Hold issue while a source is neither in registers nor bypassable.
// - FIFO line per stage holds two 6-bit register fields plus empty flags.
// - Empty slots are known by their flag, never by a zero register number.
// - Lines vacated while shifting down are cleared to zero.
// - Scoreboard keeps 63 busy bits, cleared when the register is written.
// - Bit queries use the scoreboard, number queries use the FIFO.
// - Reserve the slot at the latency level, only when it is free.
// - Part of the latency table is rewritable for wide registers.
// - Divider tracked by a down-counter loaded from the size flag.
// - Get and put stall the pipeline until they complete.
// - A buffer-hit load completes in four single-cycle steps.
// - Missed load needed next stalls so its data reaches the crossbar.
// - Size flag 00..11 means one, two, four or eight bytes.
module issue_scheduler_writeport
    import issue_sched_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic ISSUE_VALID,
    input wire ikind_t ISSUE_KIND,
    input wire logic [3:0] ISSUE_LAT,
    input wire logic [1:0] ISSUE_SIZE,
    input wire logic [3:0] ISSUE_UNIT,
    input wire logic [5:0] ISSUE_DST,
    input wire logic [5:0] ISSUE_SRC_A,
    input wire logic [5:0] ISSUE_SRC_B,
    input wire logic LAT_OVR_EN,
    input wire logic [3:0] LAT_OVR_VAL,
    input wire logic GETPUT_DONE,
    input wire logic MISS_VALID,
    input wire logic [5:0] MISS_DST,
    input wire logic [5:0] NEXT_SRC_A,
    input wire logic [5:0] NEXT_SRC_B,
    output logic ISSUE_GRANT,
    output logic ISSUE_PORT,
    output logic STALL,
    output logic MISS_TAKEN,
    output logic MISS_PORT,
    output logic [1:0] WR_EN,
    output logic [11:0] WR_REG,
    output logic [7:0] XBAR_SEL,
    output logic [63:0] BUSY_VEC
);
    localparam int D = `RSV_DEPTH;
    localparam logic [3:0] UNIT_LSU = 4'hF;
    localparam logic [3:0] UNIT_DIV = 4'hE;

    // ----------------------------------------
    // Reservation FIFO state
    // ----------------------------------------
    // line layout
    logic [5:0] rn_r [D][2];
    logic [5:0] rn_nxt [D][2];
    logic [3:0] un_r [D][2];
    logic [3:0] un_nxt [D][2];
    logic [1:0] used_r [D];
    logic [1:0] used_nxt [D];

    logic gp_busy_r;
    logic gp_busy_nxt;
    logic [5:0] div_dst_r;
    logic [5:0] div_dst_nxt;
    logic grant_r, grant_nxt, port_r, port_nxt, stall_r, stall_nxt;
    logic mt_r, mt_nxt, mp_r, mp_nxt;
    logic [1:0] wen_r, wen_nxt;
    logic [11:0] wreg_r, wreg_nxt;
    logic [7:0] xsel_r, xsel_nxt;

    logic [63:0] busy;
    logic div_busy;
    logic div_done;
    logic [3:0] lat;
    logic [2:0] lvl;
    logic lvl_ok;
    logic src_ok;
    logic can;
    logic use_fifo;
    logic sel_port;
    logic miss_ok;
    logic miss_p;
    logic do_issue;

    // ----------------------------------------
    // Operand readiness
    // ----------------------------------------
    // Bypass: a source written at level 0 this cycle is on the crossbar
    function automatic logic on_xbar(input logic [5:0] r, input logic [1:0] u0,
                                     input logic [5:0] a, input logic [5:0] b);
        on_xbar = (u0[0] && a == r) || (u0[1] && b == r);
    endfunction : on_xbar

    always_comb
    begin
        lat = LAT_OVR_EN ? LAT_OVR_VAL : ISSUE_LAT;
        if (ISSUE_KIND == K_LOAD)
        begin
            lat = `LAT_LOAD_HIT;
        end
        // number queries read FIFO, bits read scoreboard
        src_ok = (!busy[ISSUE_SRC_A] || on_xbar(ISSUE_SRC_A, used_r[0], rn_r[0][0], rn_r[0][1]))
              && (!busy[ISSUE_SRC_B] || on_xbar(ISSUE_SRC_B, used_r[0], rn_r[0][0], rn_r[0][1]));
        lvl = (lat == 4'h0) ? 3'h0 : 3'(lat - 4'h1);
        lvl_ok = (lat != 4'h0) && (lat <= 4'(D));
        use_fifo = (ISSUE_KIND == K_FIXED) || (ISSUE_KIND == K_LOAD);
        can = !(used_r[lvl][0] && used_r[lvl][1]) && lvl_ok;
        sel_port = used_r[lvl][0];
        // missed load needs a free slot at level 0
        // Taken is seen one cycle late by the unit, so never take twice in a row
        miss_ok = !(used_r[0][0] && used_r[0][1]) && !mt_r;
        miss_p = used_r[0][0];
        do_issue = ISSUE_VALID && src_ok && !gp_busy_r && !stall_r;
        if (use_fifo)
        begin
            do_issue = do_issue && can;
        end
        else if (ISSUE_KIND == K_DIV)
        begin
            do_issue = do_issue && !div_busy;
        end
    end

    // ----------------------------------------
    // FIFO shift and reserve
    // ----------------------------------------
    always_comb
    begin
        for (int i = 0; i < D; i++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                rn_nxt[i][p] = (i < D-1) ? rn_r[(i+1)%D][p] : 6'h00;
                un_nxt[i][p] = (i < D-1) ? un_r[(i+1)%D][p] : 4'h0;
            end
            used_nxt[i] = (i < D-1) ? used_r[(i+1)%D] : 2'h0;
        end
        if (do_issue && use_fifo && lvl != 3'h0)
        begin
            rn_nxt[lvl-3'h1][sel_port] = ISSUE_DST;
            un_nxt[lvl-3'h1][sel_port] = ISSUE_UNIT;
            used_nxt[lvl-3'h1][sel_port] = 1'b1;
        end
        // divider result enters the vacated top line, which nothing else uses
        if (div_done)
        begin
            rn_nxt[D-1][0] = div_dst_r;
            un_nxt[D-1][0] = UNIT_DIV;
            used_nxt[D-1][0] = 1'b1;
        end
        div_dst_nxt = div_dst_r;
        if (do_issue && ISSUE_KIND == K_DIV)
        begin
            div_dst_nxt = ISSUE_DST;
        end
    end

    always_comb
    begin
        wen_nxt = 2'h0;
        wreg_nxt = 12'h000;
        xsel_nxt = 8'h00;
        mt_nxt = 1'b0;
        mp_nxt = 1'b0;
        for (int p = 0; p < 2; p++)
        begin
            wen_nxt[p] = used_r[0][p];
            wreg_nxt[p*6 +: 6] = rn_r[0][p];
            xsel_nxt[p*4 +: 4] = un_r[0][p];
        end
        if (do_issue && use_fifo && lvl == 3'h0)
        begin
            wen_nxt[sel_port] = 1'b1;
            wreg_nxt[sel_port*6 +: 6] = ISSUE_DST;
            xsel_nxt[sel_port*4 +: 4] = ISSUE_UNIT;
        end
        else if (MISS_VALID && miss_ok)
        begin
            mt_nxt = 1'b1;
            mp_nxt = miss_p;
            wen_nxt[miss_p] = 1'b1;
            wreg_nxt[miss_p*6 +: 6] = MISS_DST;
            xsel_nxt[miss_p*4 +: 4] = UNIT_LSU;
        end
        grant_nxt = do_issue;
        port_nxt = sel_port;
        gp_busy_nxt = gp_busy_r;
        if (do_issue && ISSUE_KIND == K_GETPUT)
        begin
            gp_busy_nxt = 1'b1;
        end
        else if (GETPUT_DONE)
        begin
            gp_busy_nxt = 1'b0;
        end
        // Missed load consumed right after: hold the next instruction
        // The miss is not in the scoreboard, so match the register number itself
        stall_nxt = gp_busy_nxt
            || (MISS_VALID && MISS_DST != 6'h00
                && (NEXT_SRC_A == MISS_DST || NEXT_SRC_B == MISS_DST));
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            for (int i = 0; i < D; i++)
            begin
                rn_r[i] <= '{6'h00, 6'h00};
                un_r[i] <= '{4'h0, 4'h0};
                used_r[i] <= 2'h0;
            end
            gp_busy_r <= 1'b0;
            div_dst_r <= 6'h00;
            grant_r <= 1'b0;
            port_r <= 1'b0;
            stall_r <= 1'b0;
            mt_r <= 1'b0;
            mp_r <= 1'b0;
            wen_r <= 2'h0;
            wreg_r <= 12'h000;
            xsel_r <= 8'h00;
        end
        else
        begin
            rn_r <= rn_nxt;
            un_r <= un_nxt;
            used_r <= used_nxt;
            gp_busy_r <= gp_busy_nxt;
            div_dst_r <= div_dst_nxt;
            grant_r <= grant_nxt;
            port_r <= port_nxt;
            stall_r <= stall_nxt;
            mt_r <= mt_nxt;
            mp_r <= mp_nxt;
            wen_r <= wen_nxt;
            wreg_r <= wreg_nxt;
            xsel_r <= xsel_nxt;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // divider counter
    div_tracker u_div
    (
        .clk(CLK),
        .rst(SYS_RST),
        .start(do_issue && ISSUE_KIND == K_DIV),
        .size(ISSUE_SIZE),
        .busy(div_busy),
        .done(div_done)
    );

    score_board u_sb
    (
        .clk(CLK),
        .rst(SYS_RST),
        .set_en(do_issue && ISSUE_KIND != K_NOP && ISSUE_KIND != K_GETPUT),
        .set_reg(ISSUE_DST),
        .clr_en(wen_r),
        .clr_reg(wreg_r),
        .busy(busy)
    );

    assign ISSUE_GRANT = grant_r;
    assign ISSUE_PORT = port_r;
    assign STALL = stall_r;
    assign MISS_TAKEN = mt_r;
    assign MISS_PORT = mp_r;
    assign WR_EN = wen_r;
    assign WR_REG = wreg_r;
    assign XBAR_SEL = xsel_r;
    assign BUSY_VEC = busy;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // full level refuses
    full_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (use_fifo && used_r[lvl] == 2'h3) |-> !do_issue)
        else $error("issued into full level");
    port_free_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (do_issue && use_fifo && lvl != 3'h0) |=> used_r[$past(lvl) - 3'h1][$past(sel_port)])
        else $error("reserved port not marked");
    src_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (busy[ISSUE_SRC_A] && !on_xbar(ISSUE_SRC_A, used_r[0], rn_r[0][0], rn_r[0][1]))
        |-> !do_issue)
        else $error("issued with busy source");
    top_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !div_done |=> used_r[D-1] == 2'h0 && rn_r[D-1][0] == 6'h00)
        else $error("vacated line not cleared");
    shift_lvl_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        used_r[1][0] |=> used_r[0][0] && rn_r[0][0] == $past(rn_r[1][0]))
        else $error("fifo did not advance");
    xbar_drive_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        used_r[0][0] |=> WR_EN[0] && XBAR_SEL[3:0] == $past(un_r[0][0]))
        else $error("crossbar gate missing");
    gp_stall_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (grant_nxt && ISSUE_KIND == K_GETPUT && !GETPUT_DONE) |=> STALL)
        else $error("get/put did not stall");
    miss_slot_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (used_r[0] == 2'h3) |=> !MISS_TAKEN)
        else $error("miss took a full slot");
    miss_once_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        MISS_TAKEN |=> !MISS_TAKEN)
        else $error("miss taken twice");
endmodule : issue_scheduler_writeport
`default_nettype wire

// *** bench/exec_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Decoder side and execution units
// ----------------------------------------
module exec_model
#(
    parameter int GP_DELAY = 5,
    parameter int MISS_DELAY = 3
)
(
    input wire logic clk,
    input wire logic gp_req,
    input wire logic miss_req,
    input wire logic [5:0] miss_reg,
    input wire logic miss_taken,
    output logic getput_done,
    output logic miss_valid,
    output logic [5:0] miss_dst
);
    int gp_cnt = 0;
    int miss_cnt = 0;
    logic [5:0] held = 6'h00;

    initial
    begin
        getput_done = 1'b0;
        miss_valid = 1'b0;
        miss_dst = 6'h3F;
    end

    always @(posedge clk)
    begin
        getput_done <= (gp_cnt == 1);
        if (gp_req)
            gp_cnt <= GP_DELAY;
        else if (gp_cnt > 0)
            gp_cnt <= gp_cnt - 1;
        // data held until taken
        // Released bus shows the inverse so a stale number never matches
        if (miss_valid && miss_taken)
        begin
            miss_valid <= 1'b0;
            miss_dst <= ~held;
        end
        else if (miss_cnt == 1)
        begin
            miss_valid <= 1'b1;
            miss_dst <= held;
        end
        if (miss_req)
        begin
            miss_cnt <= MISS_DELAY;
            held <= miss_reg;
        end
        else if (miss_cnt > 0)
            miss_cnt <= miss_cnt - 1;
    end
endmodule : exec_model

`default_nettype wire

// *** bench/issue_scheduler_writeport_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "issue_sched_defs.svh"

module issue_scheduler_writeport_bench
    import issue_sched_pkg::*;
;
    logic CLK = 0, SYS_RST = 1, ISSUE_VALID = 0, LAT_OVR_EN = 0, gp_req = 0, miss_req = 0;
    ikind_t ISSUE_KIND = K_NOP;
    logic [3:0] ISSUE_LAT = 0, ISSUE_UNIT = 0, LAT_OVR_VAL = 0;
    logic [1:0] ISSUE_SIZE = 0, WR_EN;
    logic [5:0] ISSUE_DST = 0, ISSUE_SRC_A = 0, ISSUE_SRC_B = 0, NEXT_SRC_A = 0;
    logic [5:0] NEXT_SRC_B = 0, miss_reg = 0, MISS_DST;
    logic GETPUT_DONE, MISS_VALID, ISSUE_GRANT, ISSUE_PORT, STALL, MISS_TAKEN, MISS_PORT;
    logic [11:0] WR_REG;
    logic [7:0] XBAR_SEL;
    logic [63:0] BUSY_VEC;
    int fail_count = 0;
    int n_compared = 0;

    always #2 CLK = ~CLK;

    issue_scheduler_writeport DUT (.CLK(CLK), .SYS_RST(SYS_RST), .ISSUE_VALID(ISSUE_VALID),
        .ISSUE_KIND(ISSUE_KIND), .ISSUE_LAT(ISSUE_LAT), .ISSUE_SIZE(ISSUE_SIZE),
        .ISSUE_UNIT(ISSUE_UNIT), .ISSUE_DST(ISSUE_DST), .ISSUE_SRC_A(ISSUE_SRC_A),
        .ISSUE_SRC_B(ISSUE_SRC_B), .LAT_OVR_EN(LAT_OVR_EN), .LAT_OVR_VAL(LAT_OVR_VAL),
        .GETPUT_DONE(GETPUT_DONE), .MISS_VALID(MISS_VALID), .MISS_DST(MISS_DST),
        .NEXT_SRC_A(NEXT_SRC_A), .NEXT_SRC_B(NEXT_SRC_B), .ISSUE_GRANT(ISSUE_GRANT),
        .ISSUE_PORT(ISSUE_PORT), .STALL(STALL), .MISS_TAKEN(MISS_TAKEN),
        .MISS_PORT(MISS_PORT), .WR_EN(WR_EN), .WR_REG(WR_REG), .XBAR_SEL(XBAR_SEL),
        .BUSY_VEC(BUSY_VEC));

    exec_model PARTNER (.clk(CLK), .gp_req(gp_req), .miss_req(miss_req),
        .miss_reg(miss_reg), .miss_taken(MISS_TAKEN), .getput_done(GETPUT_DONE),
        .miss_valid(MISS_VALID), .miss_dst(MISS_DST));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : step

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic offer(input ikind_t k, input logic [3:0] lat, input logic [3:0] unit,
                         input logic [5:0] dst, input logic [5:0] sa);
        ISSUE_VALID = 1'b1;
        ISSUE_KIND = k;
        ISSUE_LAT = lat;
        ISSUE_UNIT = unit;
        ISSUE_DST = dst;
        ISSUE_SRC_A = sa;
    endtask : offer

    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic fixed_case(input ikind_t k, input logic [3:0] lat, input int eff,
                              input logic [3:0] unit, input logic [5:0] dst);
        int p;
        offer(k, lat, unit, dst, 6'h00);
        step(1);
        ISSUE_VALID = 1'b0;
        check("grant", ISSUE_GRANT, 1);
        p = ISSUE_PORT;
        if (eff > 1)
        begin
            check("busy set", BUSY_VEC[dst], 1);
            step(eff - 1);
        end
        check("write enable", WR_EN[p], 1);
        check("write reg", WR_REG[p*6 +: 6], dst);
        check("xbar gate", XBAR_SEL[p*4 +: 4], unit);
        step(1);
        check("busy clear", BUSY_VEC[dst], 0);
    endtask : fixed_case

    task automatic port_conflict;
        logic pa;
        offer(K_FIXED, 4'h3, 4'h1, 6'h11, 6'h00);
        step(1);
        check("grant a", ISSUE_GRANT, 1);
        pa = ISSUE_PORT;
        offer(K_FIXED, 4'h2, 4'h2, 6'h12, 6'h00);
        step(1);
        check("grant b", ISSUE_GRANT, 1);
        check("port b", ISSUE_PORT, !pa);
        offer(K_FIXED, 4'h1, 4'h3, 6'h13, 6'h00);
        step(1);
        check("grant c", ISSUE_GRANT, 0);
        check("both ports", WR_EN, 2'h3);
        ISSUE_VALID = 1'b0;
        step(3);
    endtask : port_conflict

    task automatic dependency;
        int n;
        offer(K_FIXED, 4'h4, 4'h1, 6'h21, 6'h00);
        step(1);
        check("producer", ISSUE_GRANT, 1);
        offer(K_FIXED, 4'h1, 4'h2, 6'h22, 6'h21);
        step(1);
        check("dep hold", ISSUE_GRANT, 0);
        n = 0;
        while (n < 8 && ISSUE_GRANT !== 1'b1)
        begin
            step(1);
            n++;
        end
        ISSUE_VALID = 1'b0;
        check("dep grant", ISSUE_GRANT, 1);
        step(4);
    endtask : dependency

    task automatic div_case(input logic [1:0] sz, input int cyc);
        int n;
        offer(K_DIV, 4'h0, 4'hE, 6'h30, 6'h00);
        ISSUE_SIZE = sz;
        step(1);
        check("div grant", ISSUE_GRANT, 1);
        step(1);
        check("div single", ISSUE_GRANT, 0);
        ISSUE_VALID = 1'b0;
        n = 1;
        while (n < 100 && !(WR_EN[0] === 1'b1 && XBAR_SEL[3:0] === 4'hE)
               && !(WR_EN[1] === 1'b1 && XBAR_SEL[7:4] === 4'hE))
        begin
            step(1);
            n++;
        end
        // Done takes port 0 of the unused top line with no wait; the write lands one cycle after the count
        check("div count", (n >= cyc - 2 && n <= cyc + 2), 1);
        step(1);
        check("div busy clear", BUSY_VEC[6'h30], 0);
        step(1);
    endtask : div_case

    task automatic getput;
        int n;
        offer(K_GETPUT, 4'h0, 4'h0, 6'h00, 6'h00);
        step(1);
        ISSUE_VALID = 1'b0;
        gp_req = 1'b1;
        step(1);
        gp_req = 1'b0;
        check("gp stall", STALL, 1);
        offer(K_FIXED, 4'h1, 4'h1, 6'h05, 6'h00);
        step(1);
        ISSUE_VALID = 1'b0;
        check("gp hold", ISSUE_GRANT, 0);
        n = 0;
        while (n < 40 && STALL !== 1'b0)
        begin
            step(1);
            n++;
        end
        check("gp release", STALL, 0);
        step(2);
    endtask : getput

    task automatic missed_load;
        logic st, tk;
        st = 1'b0;
        tk = 1'b0;
        NEXT_SRC_A = 6'h2A;
        miss_reg = 6'h2A;
        miss_req = 1'b1;
        step(1);
        miss_req = 1'b0;
        repeat (20)
        begin
            st |= (STALL === 1'b1);
            tk |= (MISS_TAKEN === 1'b1);
            if (MISS_TAKEN === 1'b1)
                check("miss port", MISS_PORT, 0);
            step(1);
        end
        check("miss stall", st, 1);
        check("miss taken", tk, 1);
        NEXT_SRC_A = 6'h00;
        step(2);
    endtask : missed_load

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        #(4 * 20000);
        fail_count++;
        final_report();
    end

    initial
    begin
        step(4);
        SYS_RST = 1'b0;
        check("reset busy", BUSY_VEC, 0);
        fixed_case(K_FIXED, 4'h2, 2, 4'h1, 6'h05);
        fixed_case(K_FIXED, 4'h1, 1, 4'h2, 6'h06);
        fixed_case(K_FIXED, `LAT_MUL, 6, 4'h3, 6'h07);
        fixed_case(K_LOAD, 4'h1, `LAT_LOAD_HIT, 4'hF, 6'h08);
        LAT_OVR_EN = 1'b1;
        LAT_OVR_VAL = 4'h3;
        fixed_case(K_FIXED, 4'h6, 3, 4'h4, 6'h09);
        LAT_OVR_EN = 1'b0;
        port_conflict();
        dependency();
        div_case(`SZ_BYTE, 8);
        div_case(`SZ_DBYTE, 16);
        div_case(`SZ_QBYTE, 32);
        div_case(`SZ_OBYTE, 64);
        getput();
        missed_load();
        final_report();
    end
endmodule : issue_scheduler_writeport_bench

`default_nettype wire
